// ===== cgacr_pkg.sv
// Register map, field positions, reset values and step sizes of the gain/AGC control bank
// Assumes a 16-bit word register port with 7-bit register index
package cgacr_pkg;
    localparam logic [6:0]  ADDR_PLL_FRACTION = 7'h1C;
    localparam logic [6:0]  ADDR_AUDIO_CTRL4  = 7'h1D;
    localparam logic [6:0]  ADDR_HANDSET_GAIN = 7'h1E;
    localparam logic [13:0] FRACTION_MAX      = 14'h270F;
    localparam logic [15:0] RST_PLL_FRACTION  = 16'h0000;
    localparam logic [15:0] RST_AUDIO_CTRL4   = 16'h0000;
    localparam logic [15:0] RST_HANDSET_GAIN  = 16'hFF00;
    localparam logic [15:0] MASK_AUDIO_CTRL4  = 16'hFFC0;
    localparam int          BIT_INPUT_STEPD   = 15;
    localparam int          BIT_DAC_STEPD     = 14;
    localparam int          BIT_SIDE_STEPD    = 13;
    localparam int          BIT_CELL_STEPD    = 12;
    localparam int          BIT_BUZZ_STEPD    = 11;
    localparam int          BIT_SHORT_FLAG    = 1;
    localparam int          BIT_HS_MUTE       = 15;
    localparam int          BIT_LOOP_ENABLE   = 0;
    localparam logic [6:0]  STEP_HALF_DB      = 7'h01;
    localparam logic [6:0]  STEP_THREE_DB     = 7'h06;
    localparam logic [1:0]  HYS_NONE          = 2'h3;
endpackage : cgacr_pkg

// ===== cgacr_stepper.sv
// One soft-stepping gain ramp in half-dB code units
// Assumes tick_i pulses once per reference sample period
`timescale 1ns/100ps
`default_nettype none
module cgacr_stepper
    import cgacr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       disable_i,
    input  wire logic [6:0] step_i,
    input  wire logic [6:0] target_i,
    output logic      [6:0] gain_o,
    output logic            settled_o
);
    logic [6:0] gain;
    logic [6:0] next_gain;
    logic [6:0] diff;

    always_comb begin
        next_gain = gain;
        diff      = (target_i > gain) ? (target_i - gain) : (gain - target_i);
        if (tick_i) begin
            if (disable_i || diff <= step_i) begin
                next_gain = target_i;
            end else if (target_i > gain) begin
                next_gain = 7'(gain + step_i);
            end else begin
                next_gain = 7'(gain - step_i);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain <= 7'h00;
        end else begin
            gain <= next_gain;
        end
    end

    assign gain_o    = gain;
    assign settled_o = (gain == target_i);
endmodule : cgacr_stepper
`default_nettype wire

// ===== cgacr_timebase.sv
// Sample-rate-scaled millisecond tick for the gain loop timing
// Assumes tick_i pulses at the reference sample rate given on rate_i in samples per ms
`timescale 1ns/100ps
`default_nettype none
module cgacr_timebase
    import cgacr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic [7:0] rate_i,
    output logic            ms_tick_o
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       ms_tick;
    logic       next_ms_tick;

    always_comb begin
        next_count   = count;
        next_ms_tick = 1'b0;
        if (tick_i) begin
            if (count + 8'h01 >= rate_i) begin
                next_count   = 8'h00;
                next_ms_tick = 1'b1;
            end else begin
                next_count = 8'(count + 8'h01);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count   <= 8'h00;
            ms_tick <= 1'b0;
        end else begin
            count   <= next_count;
            ms_tick <= next_ms_tick;
        end
    end

    assign ms_tick_o = ms_tick;
endmodule : cgacr_timebase
`default_nettype wire

// ===== cgacr_regs.sv
// What this block does
// - Fraction divider in bits 15..2, values above 9999 clamp to 9999.
// - Five step-disable bits: 0 enables soft-stepping, 1 disables it.
// - Sidetone and cellular gains step 0.5 dB per sample period.
// - Buzzer gain steps 3 dB per sample period.
// - Hysteresis code 00/01/10 gives 1/2/4 dB, 11 none, only with the loop on and the handset selected.
// - Headset bias code 00 gives 3.3 V, 01 2.5 V, else 2.0 V.
// - Handset bias bit 0 gives 2.5 V, 1 gives 2.0 V.
// - Read-only short fault bit reads 1 once a headphone short was seen.
// - Handset mute bit mutes when 1 and resets to 1.
// - Seven-bit handset gain, 0.5 dB per code, resets to all ones.
// - Under loop control with handset selected, mute and gain read applied gain.
// - Applied gain reads as eight-bit signed half-dB code, +59.5 to -12 dB.
// - Three-bit target field selects ADC output level -5.5 to -22 dB.
// - Four-bit timing field: low bits attack time, high bits decay time.
// - Loop times stay fixed in absolute time whatever the sample rate.
// - Loop enable 0 uses register gain, 1 lets the loop drive the gain.
// - Sidetone, cellular and buzzer settled flags read 1 when applied gain equals setting.
// Holds registers 1Ch..1Eh of the codec control bank
// Assumes a synchronous 16-bit word port and analog/loop logic outside
`timescale 1ns/100ps
`default_nettype none
module cgacr_regs
    import cgacr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        sample_tick_i,
    input  wire logic [7:0]  samples_per_ms_i,
    input  wire logic        short_detect_i,
    input  wire logic        handset_selected_i,
    input  wire logic [7:0]  loop_gain_i,
    input  wire logic [6:0]  sidetone_target_i,
    input  wire logic [6:0]  cellular_target_i,
    input  wire logic [6:0]  buzzer_target_i,
    output logic      [13:0] pll_fraction_value_o,
    output logic             input_pga_step_disable_o,
    output logic             dac_pga_step_disable_o,
    output logic      [6:0]  sidetone_gain_o,
    output logic      [6:0]  cellular_gain_o,
    output logic      [6:0]  buzzer_gain_o,
    output logic             sidetone_gain_settled_o,
    output logic             cellular_gain_settled_o,
    output logic             buzzer_gain_settled_o,
    output logic      [2:0]  hysteresis_db_o,
    output logic      [1:0]  headset_bias_level_o,
    output logic             handset_bias_level_o,
    output logic             handset_mute_o,
    output logic      [6:0]  handset_gain_code_o,
    output logic             handset_loop_active_o,
    output logic      [2:0]  handset_loop_target_o,
    output logic      [1:0]  attack_select_o,
    output logic      [1:0]  decay_select_o,
    output logic             loop_ms_tick_o
);
    logic [15:0] pll_fraction_divider;
    logic [15:0] audio_control_four;
    logic [15:0] handset_input_gain;
    logic        short_fault_flag;
    logic [15:0] next_pll_fraction_divider;
    logic [15:0] next_audio_control_four;
    logic [15:0] next_handset_input_gain;
    logic        next_short_fault_flag;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic [13:0] frac_in;
    logic        loop_on;

    assign frac_in = reg_wdata_i[15:2];
    assign loop_on = handset_input_gain[BIT_LOOP_ENABLE] && handset_selected_i;

    always_comb begin
        next_pll_fraction_divider = pll_fraction_divider;
        next_audio_control_four   = audio_control_four;
        next_handset_input_gain   = handset_input_gain;
        next_short_fault_flag     = short_fault_flag;
        if (reg_write_i) begin
            case (reg_addr_i)
                ADDR_PLL_FRACTION: begin
                    next_pll_fraction_divider = {(frac_in > FRACTION_MAX) ? FRACTION_MAX : frac_in, 2'b00};
                end
                ADDR_AUDIO_CTRL4: begin
                    next_audio_control_four = reg_wdata_i & MASK_AUDIO_CTRL4;
                end
                ADDR_HANDSET_GAIN: begin
                    next_handset_input_gain = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
        if (reg_read_i && reg_addr_i == ADDR_AUDIO_CTRL4 && !short_detect_i) begin
            next_short_fault_flag = 1'b0;
        end
        if (short_detect_i) begin
            next_short_fault_flag = 1'b1;
        end
    end

    always_comb begin
        next_rdata = rdata;
        if (reg_read_i) begin
            case (reg_addr_i)
                ADDR_PLL_FRACTION: next_rdata = pll_fraction_divider;
                ADDR_AUDIO_CTRL4: begin
                    next_rdata                 = audio_control_four;
                    next_rdata[BIT_SHORT_FLAG] = short_fault_flag;
                end
                ADDR_HANDSET_GAIN: begin
                    next_rdata = handset_input_gain;
                    if (loop_on) begin
                        next_rdata[15:8] = loop_gain_i;
                    end
                end
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pll_fraction_divider <= RST_PLL_FRACTION;
            audio_control_four   <= RST_AUDIO_CTRL4;
            handset_input_gain   <= RST_HANDSET_GAIN;
            short_fault_flag     <= 1'b0;
            rdata                <= 16'h0000;
        end else begin
            pll_fraction_divider <= next_pll_fraction_divider;
            audio_control_four   <= next_audio_control_four;
            handset_input_gain   <= next_handset_input_gain;
            short_fault_flag     <= next_short_fault_flag;
            rdata                <= next_rdata;
        end
    end

    logic      [2:0][6:0] step_size;
    logic      [2:0][6:0] step_target;
    logic      [2:0]      step_off;
    wire logic [2:0][6:0] step_gain;
    wire logic [2:0]      step_done;

    // Channel 0 sidetone, 1 cellular, 2 buzzer
    assign step_size   = {STEP_THREE_DB, STEP_HALF_DB, STEP_HALF_DB};
    assign step_target = {buzzer_target_i, cellular_target_i, sidetone_target_i};
    assign step_off    = {audio_control_four[BIT_BUZZ_STEPD], audio_control_four[BIT_CELL_STEPD],
                          audio_control_four[BIT_SIDE_STEPD]};

    for (genvar ch = 0; ch < 3; ch++) begin : g_stepper
        cgacr_stepper u_stepper (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .tick_i    (sample_tick_i),
            .disable_i (step_off[ch]),
            .step_i    (step_size[ch]),
            .target_i  (step_target[ch]),
            .gain_o    (step_gain[ch]),
            .settled_o (step_done[ch])
        );
    end

    assign sidetone_gain_o         = step_gain[0];
    assign cellular_gain_o         = step_gain[1];
    assign buzzer_gain_o           = step_gain[2];
    assign sidetone_gain_settled_o = step_done[0];
    assign cellular_gain_settled_o = step_done[1];
    assign buzzer_gain_settled_o   = step_done[2];

    cgacr_timebase u_timebase (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (sample_tick_i),
        .rate_i    (samples_per_ms_i),
        .ms_tick_o (loop_ms_tick_o)
    );

    always_comb begin
        case (audio_control_four[10:9])
            2'h0:    hysteresis_db_o = loop_on ? 3'h1 : 3'h0;
            2'h1:    hysteresis_db_o = loop_on ? 3'h2 : 3'h0;
            2'h2:    hysteresis_db_o = loop_on ? 3'h4 : 3'h0;
            default: hysteresis_db_o = 3'h0;
        endcase
    end

    always_comb begin
        case (audio_control_four[8:7])
            2'h0:    headset_bias_level_o = 2'h0;
            2'h1:    headset_bias_level_o = 2'h1;
            default: headset_bias_level_o = 2'h2;
        endcase
    end

    assign handset_bias_level_o     = audio_control_four[6];
    assign reg_rdata_o              = rdata;
    assign pll_fraction_value_o     = pll_fraction_divider[15:2];
    assign input_pga_step_disable_o = audio_control_four[BIT_INPUT_STEPD];
    assign dac_pga_step_disable_o   = audio_control_four[BIT_DAC_STEPD];
    assign handset_mute_o           = handset_input_gain[BIT_HS_MUTE];
    assign handset_gain_code_o      = handset_input_gain[14:8];
    assign handset_loop_active_o    = handset_input_gain[BIT_LOOP_ENABLE];
    assign handset_loop_target_o    = handset_input_gain[7:5];
    assign attack_select_o          = handset_input_gain[2:1];
    assign decay_select_o           = handset_input_gain[4:3];
endmodule : cgacr_regs
`default_nettype wire

// ===== cgacr_regs_props.sv
// Checker for the gain/AGC register bank ports
// Assumes one clock domain and an async active-high reset
`timescale 1ns/100ps
`default_nettype none
module cgacr_regs_props
    import cgacr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        reg_write_i,
    input wire logic [6:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        sample_tick_i,
    input wire logic [6:0]  cellular_target_i,
    input wire logic [13:0] pll_fraction_value_o,
    input wire logic        input_pga_step_disable_o,
    input wire logic [6:0]  buzzer_gain_o,
    input wire logic [6:0]  cellular_gain_o,
    input wire logic        cellular_gain_settled_o,
    input wire logic [1:0]  headset_bias_level_o,
    input wire logic        handset_mute_o,
    input wire logic [6:0]  handset_gain_code_o,
    input wire logic        loop_ms_tick_o
);
    logic [15:0] wd_q;
    logic        wr_1c;
    logic        wr_1d;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign wr_1c = reg_write_i && (reg_addr_i == ADDR_PLL_FRACTION);
    assign wr_1d = reg_write_i && (reg_addr_i == ADDR_AUDIO_CTRL4);
    always_ff @(posedge clk_i) wd_q <= reg_wdata_i;
    frac_clamp_a: assert property (wr_1c |=> pll_fraction_value_o ==
        ((wd_q[15:2] > FRACTION_MAX) ? FRACTION_MAX : wd_q[15:2])) else $error("fraction clamp wrong");
    step_bit_a: assert property (wr_1d |=> input_pga_step_disable_o == wd_q[15])
        else $error("step disable bit wrong");
    head_bias_a: assert property (wr_1d |=> headset_bias_level_o ==
        (wd_q[8] ? 2'h2 : {1'b0, wd_q[7]})) else $error("headset bias wrong");
    buzz_hold_a: assert property (!sample_tick_i |=> $stable(buzzer_gain_o))
        else $error("buzzer gain moved without tick");
    cell_hold_a: assert property (!sample_tick_i |=> $stable(cellular_gain_o))
        else $error("cellular gain moved without tick");
    cell_flag_a: assert property (cellular_gain_settled_o == (cellular_gain_o == cellular_target_i))
        else $error("settled flag wrong");
    mute_reset_a: assert property ($fell(rst_i) |-> handset_mute_o && handset_gain_code_o == 7'h7F)
        else $error("handset reset value wrong");
    ms_pulse_a: assert property (loop_ms_tick_o |=> !loop_ms_tick_o)
        else $error("ms tick longer than one cycle");
endmodule : cgacr_regs_props
bind cgacr_regs cgacr_regs_props cgacr_regs_props_i (.*);
`default_nettype wire

// ===== cgacr_host_model.sv
// Host model for the word register port
// Assumes its tasks are called from one process
`timescale 1ns/100ps
`default_nettype none
module cgacr_host_model
    import cgacr_pkg::*;
(
    input  wire logic        clk_i,
    output logic             reg_write_o = 1'b0,
    output logic             reg_read_o = 1'b0,
    output logic      [6:0]  reg_addr_o = 7'h00,
    output logic      [15:0] reg_wdata_o = 16'h0000,
    input  wire logic [15:0] reg_rdata_i
);
    // Idle bus shows inverted values, never the last transfer
    task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        #1;
        reg_write_o = w;
        reg_read_o  = !w;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        q           = reg_rdata_i;
        reg_write_o = 1'b0;
        reg_read_o  = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : xfer
endmodule : cgacr_host_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the gain/AGC register bank
// Assumes checker and host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cgacr_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, sample_tick_i = 1'b0, short_detect_i = 1'b0;
    logic        reg_write_i, reg_read_i, handset_selected_i = 1'b0;
    logic [6:0]  reg_addr_i, sidetone_target_i = 7'h00, cellular_target_i = 7'h00, buzzer_target_i = 7'h00;
    logic [15:0] reg_wdata_i, reg_rdata_o, q;
    logic [7:0]  samples_per_ms_i = 8'h04, loop_gain_i = 8'h00;
    logic [13:0] pll_fraction_value_o;
    logic [6:0]  sidetone_gain_o, cellular_gain_o, buzzer_gain_o, handset_gain_code_o;
    logic [2:0]  hysteresis_db_o, handset_loop_target_o;
    logic [1:0]  headset_bias_level_o, attack_select_o, decay_select_o;
    logic        input_pga_step_disable_o, dac_pga_step_disable_o, handset_bias_level_o, handset_mute_o;
    logic        sidetone_gain_settled_o, cellular_gain_settled_o, buzzer_gain_settled_o;
    logic        handset_loop_active_o, loop_ms_tick_o;
    int          n_mismatch = 0, total_checks = 0, nms = 0, n0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (loop_ms_tick_o) nms++;
    cgacr_regs cgacr_regs_i (.*);
    cgacr_host_model cgacr_host_model_i (.clk_i(clk_i), .reg_write_o(reg_write_i), .reg_read_o(reg_read_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        cgacr_host_model_i.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        cgacr_host_model_i.xfer(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask : rdc
    task automatic pulse;
        @(posedge clk_i);
        #1;
        sample_tick_i = 1'b1;
        @(posedge clk_i);
        #1;
        sample_tick_i = 1'b0;
    endtask : pulse
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rdc(ADDR_PLL_FRACTION, 16'h0000);
        rdc(ADDR_HANDSET_GAIN, 16'hFF00);
        wr(ADDR_PLL_FRACTION, 16'hFFFC);
        rdc(ADDR_PLL_FRACTION, 16'h9C3C);
        wr(ADDR_PLL_FRACTION, 16'h9C38);
        chk(16'(pll_fraction_value_o), 16'h270E);
        wr(7'h20, 16'hFFFF);
        rdc(7'h20, 16'h0000);
        rdc(ADDR_PLL_FRACTION, 16'h9C38);
        $display("fraction test done");
        wr(ADDR_AUDIO_CTRL4, 16'hFFFF);
        rdc(ADDR_AUDIO_CTRL4, 16'hFFC0);
        chk({14'h0, input_pga_step_disable_o, dac_pga_step_disable_o}, 16'h0003);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_AUDIO_CTRL4, 16'((c << 7) | ((c & 1) << 6)));
            chk({13'h0, handset_bias_level_o, headset_bias_level_o}, 16'(((c & 1) << 2) | (c > 1 ? 2 : c)));
        end
        wr(ADDR_HANDSET_GAIN, 16'h2B5B);
        handset_selected_i = 1'b1;
        for (int h = 0; h < 4; h++) begin
            wr(ADDR_AUDIO_CTRL4, 16'(h << 9));
            repeat (2) @(posedge clk_i);
            chk(16'(hysteresis_db_o), 16'(h == 3 ? 0 : 1 << h));
        end
        $display("control test done");
        loop_gain_i = 8'hE8;
        rdc(ADDR_HANDSET_GAIN, 16'hE85B);
        loop_gain_i = 8'h77;
        rdc(ADDR_HANDSET_GAIN, 16'h775B);
        handset_selected_i = 1'b0;
        rdc(ADDR_HANDSET_GAIN, 16'h2B5B);
        chk({handset_mute_o, handset_gain_code_o, handset_loop_target_o, decay_select_o, attack_select_o,
            handset_loop_active_o}, 16'h2B5B);
        wr(ADDR_HANDSET_GAIN, 16'h2B5A);
        handset_selected_i = 1'b1;
        rdc(ADDR_HANDSET_GAIN, 16'h2B5A);
        $display("handset test done");
        wr(ADDR_AUDIO_CTRL4, 16'h0000);
        chk(16'(hysteresis_db_o), 16'h0000);
        chk({14'h0, input_pga_step_disable_o, dac_pga_step_disable_o}, 16'h0000);
        short_detect_i = 1'b1;
        rdc(ADDR_AUDIO_CTRL4, 16'h0002);
        rdc(ADDR_AUDIO_CTRL4, 16'h0002);
        short_detect_i = 1'b0;
        rdc(ADDR_AUDIO_CTRL4, 16'h0002);
        rdc(ADDR_AUDIO_CTRL4, 16'h0000);
        $display("short test done");
        {sidetone_target_i, cellular_target_i, buzzer_target_i} = {7'd10, 7'd3, 7'd20};
        pulse();
        chk(16'({buzzer_gain_o, sidetone_gain_o}), 16'({7'd6, 7'd1}));
        pulse();
        pulse();
        chk(16'({buzzer_gain_o, sidetone_gain_o}), 16'({7'd18, 7'd3}));
        chk(16'({sidetone_gain_settled_o, cellular_gain_settled_o, cellular_gain_o}), 16'h0083);
        pulse();
        chk(16'({buzzer_gain_settled_o, buzzer_gain_o}), 16'h0094);
        wr(ADDR_AUDIO_CTRL4, 16'h2000);
        {sidetone_target_i, cellular_target_i} = {7'h50, 7'h10};
        pulse();
        chk(16'({sidetone_gain_o, 1'b0, cellular_gain_o}), 16'h5004);
        repeat (2) @(posedge clk_i);
        n0 = nms;
        repeat (8) pulse();
        repeat (2) @(posedge clk_i);
        chk(16'(nms - n0), 16'h0002);
        $display("stepping test done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
